// ---- common/dit_regs.vh ----
/*
  Register indices, field positions, reset values and divider counts of the
  dual 8-bit interval timer. Assumes APB byte address = index * 4.
*/
`ifndef DIT_REGS_VH
`define DIT_REGS_VH

`define DIT_ADDR_W         18
`define DIT_IDX_W          16
`define DIT_IDX_PORT2_DIR  16'hff22
`define DIT_IDX_PRI_CTRL   16'hff30
`define DIT_IDX_SEC_CTRL   16'hff31
`define DIT_IDX_PRI_CMP    16'hff32
`define DIT_IDX_SEC_CMP    16'hff33
`define DIT_IDX_PRI_CNT    16'hff34
`define DIT_IDX_SEC_CNT    16'hff35
`define DIT_IDX_PIN_LATCH  16'hff36
`define DIT_IDX_PIN_STATE  16'hff37

`define DIT_RST_PORT2_DIR  8'hff
`define DIT_RST_CTRL       8'h00
`define DIT_RST_CMP        8'h00
`define DIT_RST_LATCH      8'h00
`define DIT_DIR_FIXED      8'hfc
`define DIT_PRI_CTRL_MASK  8'hb9
`define DIT_SEC_CTRL_MASK  8'hb8
`define DIT_LATCH_MASK     8'h03

`define DIT_CTRL_EN_BIT    7
`define DIT_CTRL_CLK_HI    5
`define DIT_CTRL_CLK_LO    3
`define DIT_CTRL_OE_BIT    0
`define DIT_DIR_OUT_PIN    0
`define DIT_DIR_CLK_PIN    1

`define DIT_DIV_PRI_SLOW   4
`define DIT_DIV_SEC_FAST   64
`define DIT_DIV_SEC_SLOW   256
`define DIT_EXT_DIV_N      4

`define DIT_CLK_SYS        3'h0
`define DIT_CLK_SYS4       3'h1
`define DIT_CLK_EXT1       3'h2
`define DIT_CLK_EXT2       3'h3
`define DIT_CLK_EXT4       3'h4
`define DIT_CLK_EXT8       3'h5
`define DIT_CLK_S64        3'h0
`define DIT_CLK_S256       3'h1
`define DIT_CLK_PMATCH     3'h2
`define DIT_CLK_PCARR      3'h3

`endif

// ---- hdl/dit_prescale.v ----
/*
  Prescaler: one-cycle enable pulses at system clock /4, /64, /256 and
  external-pin rising edges divided by 1, 2, 4, 8. Assumes the pin input
  is already synchronous to the clock.
*/
`default_nettype none
`include "dit_regs.vh"

module dit_prescale #(
  parameter DIV_W = 8
) (
  input  wire                       clk,
  input  wire                       rst_n,
  input  wire                       ext_pin,
  output reg                        tick_sys4,
  output reg                        tick_sys64,
  output reg                        tick_sys256,
  output reg  [`DIT_EXT_DIV_N-1:0]  tick_ext
);

  reg  [DIV_W-1:0]            div_r;
  reg                         ext_prev_r;
  reg  [`DIT_EXT_DIV_N-2:0]   ext_cnt_r;
  wire                        ext_edge;
  wire [`DIT_EXT_DIV_N-1:0]   ext_nxt;

  assign ext_edge = ext_pin & ~ext_prev_r;

  // Tap i fires on every 2**i-th edge of the pin
  genvar i;
  generate
    for (i = 0; i < `DIT_EXT_DIV_N; i = i + 1)
    begin : g_ext
      if (i == 0)
      begin : g_one
        assign ext_nxt[i] = ext_edge;
      end
      else
      begin : g_div
        assign ext_nxt[i] = ext_edge & (&ext_cnt_r[i-1:0]);
      end
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_r       <= {DIV_W{1'b0}};
      ext_prev_r  <= 1'b0;
      ext_cnt_r   <= {(`DIT_EXT_DIV_N-1){1'b0}};
      tick_sys4   <= 1'b0;
      tick_sys64  <= 1'b0;
      tick_sys256 <= 1'b0;
      tick_ext    <= {`DIT_EXT_DIV_N{1'b0}};
    end
    else
    begin
      div_r       <= div_r + 1'b1;
      ext_prev_r  <= ext_pin;
      tick_sys4   <= (div_r[1:0] == 2'h3);
      tick_sys64  <= (div_r[5:0] == 6'h3f);
      tick_sys256 <= (div_r == {DIV_W{1'b1}});
      tick_ext    <= ext_nxt;
      if (ext_edge)
        ext_cnt_r <= ext_cnt_r + 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/dit_timer.v ----
/*
  One 8-bit interval timer channel: up-counter with compare-and-clear.
  Assumes tick is a one-cycle enable on the chosen count clock.
*/
`default_nettype none

module dit_timer #(
  parameter CNT_W = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             enable,
  input  wire             tick,
  input  wire [CNT_W-1:0] compare,
  output reg  [CNT_W-1:0] count_r,
  output reg              match_r
);

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_r <= {CNT_W{1'b0}};
      match_r <= 1'b0;
    end
    else if (!enable)
    begin
      count_r <= {CNT_W{1'b0}};
      match_r <= 1'b0;
    end
    else if (tick)
    begin
      if (count_r == compare)
      begin
        count_r <= {CNT_W{1'b0}};
        match_r <= 1'b1;
      end
      else
      begin
        // Plain wrap past the top value gives the late match of a lowered compare
        count_r <= count_r + 1'b1;
        match_r <= 1'b0;
      end
    end
    else
    begin
      match_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/dit_top.v ----
/*
  Dual 8-bit interval timer with port-2 direction register, APB slave.
  Assumes APB signals synchronous to CLOCK, one clock, synchronous reset.
*/
`default_nettype none
`include "dit_regs.vh"

module dit_top #(
  parameter CNT_W = 8
) (
  input  wire                   CLOCK,
  input  wire                   RESETN,
  input  wire                   PSEL,
  input  wire                   PENABLE,
  input  wire                   PWRITE,
  input  wire [`DIT_ADDR_W-1:0] PADDR,
  input  wire [31:0]            PWDATA,
  output reg  [31:0]            PRDATA,
  output wire                   PREADY,
  output reg                    PSLVERR,
  input  wire                   EXT_CLK_IN,
  output reg                    TMO_OUT,
  output wire                   TMO_OE,
  output wire                   PIN1_OUT,
  output wire                   PIN1_OE,
  output wire                   PRI_IRQ,
  output wire                   SEC_IRQ
);

  // Register decode shared by read and write paths
  function addr_hit;
    input [`DIT_ADDR_W-1:0] addr;
    input [`DIT_IDX_W-1:0]  idx;
    begin
      addr_hit = (addr[1:0] == 2'h0) && (addr[`DIT_ADDR_W-1:2] == idx);
    end
  endfunction

  // Set of all mapped indices
  function addr_known;
    input [`DIT_ADDR_W-1:0] addr;
    begin
      addr_known = addr_hit(addr, `DIT_IDX_PORT2_DIR)
                || addr_hit(addr, `DIT_IDX_PRI_CTRL)
                || addr_hit(addr, `DIT_IDX_SEC_CTRL)
                || addr_hit(addr, `DIT_IDX_PRI_CMP)
                || addr_hit(addr, `DIT_IDX_SEC_CMP)
                || addr_hit(addr, `DIT_IDX_PRI_CNT)
                || addr_hit(addr, `DIT_IDX_SEC_CNT)
                || addr_hit(addr, `DIT_IDX_PIN_LATCH)
                || addr_hit(addr, `DIT_IDX_PIN_STATE);
    end
  endfunction

  // Port-2 pins served here: timer output pin and clock-in pin
  localparam PIN_N = 2;

  // Software-visible state
  reg  [7:0]       port2_direction_r;
  reg  [7:0]       pri_ctrl_r;
  reg  [7:0]       sec_ctrl_r;
  reg  [CNT_W-1:0] primary_compare_r;
  reg  [CNT_W-1:0] secondary_compare_r;
  reg  [7:0]       pin_latch_r;

  // Timer-side state
  reg              tmo_ff_r;
  reg              carrier_prev_r;
  reg  [7:0]       rdata_nxt;

  wire             wr_en;
  wire             setup_phase;
  wire             tick_sys4;
  wire             tick_sys64;
  wire             tick_sys256;
  wire [`DIT_EXT_DIV_N-1:0] tick_ext;
  wire [2:0]       primary_clksel;
  wire [2:0]       secondary_clksel;
  wire             primary_count_enable;
  wire             secondary_count_enable;
  wire             pin_output_enable;
  reg              pri_tick;
  reg              sec_tick;
  wire             carrier_edge;
  wire [CNT_W-1:0] primary_counter;
  wire [CNT_W-1:0] secondary_counter;
  wire             primary_match_irq;
  wire             secondary_match_irq;
  wire [PIN_N-1:0] pin_oe;
  wire [PIN_N-1:0] pin_level;

  assign setup_phase = PSEL & ~PENABLE;
  // Zero-wait slave: read data is prepared in the setup cycle
  assign PREADY      = PSEL & PENABLE;
  assign wr_en       = PSEL & PENABLE & PWRITE;

  assign primary_clksel         = pri_ctrl_r[`DIT_CTRL_CLK_HI:`DIT_CTRL_CLK_LO];
  assign secondary_clksel       = sec_ctrl_r[`DIT_CTRL_CLK_HI:`DIT_CTRL_CLK_LO];
  assign primary_count_enable   = pri_ctrl_r[`DIT_CTRL_EN_BIT];
  assign secondary_count_enable = sec_ctrl_r[`DIT_CTRL_EN_BIT];
  assign pin_output_enable      = pri_ctrl_r[`DIT_CTRL_OE_BIT];

  // Register writes
  always @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      port2_direction_r   <= `DIT_RST_PORT2_DIR;
      pri_ctrl_r          <= `DIT_RST_CTRL;
      sec_ctrl_r          <= `DIT_RST_CTRL;
      primary_compare_r   <= `DIT_RST_CMP;
      secondary_compare_r <= `DIT_RST_CMP;
      pin_latch_r         <= `DIT_RST_LATCH;
    end
    else if (wr_en)
    begin
      if (addr_hit(PADDR, `DIT_IDX_PORT2_DIR))
        port2_direction_r <= PWDATA[7:0] | `DIT_DIR_FIXED;
      if (addr_hit(PADDR, `DIT_IDX_PRI_CTRL))
        pri_ctrl_r <= PWDATA[7:0] & `DIT_PRI_CTRL_MASK;
      if (addr_hit(PADDR, `DIT_IDX_SEC_CTRL))
        sec_ctrl_r <= PWDATA[7:0] & `DIT_SEC_CTRL_MASK;
      // Compare takes effect at once; a lower value waits for the wrap
      if (addr_hit(PADDR, `DIT_IDX_PRI_CMP))
        primary_compare_r <= PWDATA[CNT_W-1:0];
      if (addr_hit(PADDR, `DIT_IDX_SEC_CMP))
        secondary_compare_r <= PWDATA[CNT_W-1:0];
      if (addr_hit(PADDR, `DIT_IDX_PIN_LATCH))
        pin_latch_r <= PWDATA[7:0] & `DIT_LATCH_MASK;
    end
  end

  // Read mux
  always @*
  begin
    rdata_nxt = 8'h00;
    if (addr_hit(PADDR, `DIT_IDX_PORT2_DIR))
      rdata_nxt = port2_direction_r;
    else if (addr_hit(PADDR, `DIT_IDX_PRI_CTRL))
      rdata_nxt = pri_ctrl_r;
    else if (addr_hit(PADDR, `DIT_IDX_SEC_CTRL))
      rdata_nxt = sec_ctrl_r;
    else if (addr_hit(PADDR, `DIT_IDX_PRI_CMP))
      rdata_nxt = primary_compare_r;
    else if (addr_hit(PADDR, `DIT_IDX_SEC_CMP))
      rdata_nxt = secondary_compare_r;
    else if (addr_hit(PADDR, `DIT_IDX_PRI_CNT))
      rdata_nxt = primary_counter;
    else if (addr_hit(PADDR, `DIT_IDX_SEC_CNT))
      rdata_nxt = secondary_counter;
    else if (addr_hit(PADDR, `DIT_IDX_PIN_LATCH))
      rdata_nxt = pin_latch_r;
    else if (addr_hit(PADDR, `DIT_IDX_PIN_STATE))
      rdata_nxt = {6'h00, EXT_CLK_IN, TMO_OUT};
  end

  // Response registers, captured in the setup cycle
  always @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (setup_phase)
    begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rdata_nxt};
      PSLVERR <= ~addr_known(PADDR);
    end
    else if (!PSEL)
    begin
      PSLVERR <= 1'b0;
    end
  end

  dit_prescale #(
    .DIV_W (8)
  ) u_prescale (
    .clk         (CLOCK),
    .rst_n       (RESETN),
    .ext_pin     (EXT_CLK_IN),
    .tick_sys4   (tick_sys4),
    .tick_sys64  (tick_sys64),
    .tick_sys256 (tick_sys256),
    .tick_ext    (tick_ext)
  );

  // Primary count clock select
  always @*
  begin
    case (primary_clksel)
      `DIT_CLK_SYS:  pri_tick = 1'b1;
      `DIT_CLK_SYS4: pri_tick = tick_sys4;
      `DIT_CLK_EXT1: pri_tick = tick_ext[0];
      `DIT_CLK_EXT2: pri_tick = tick_ext[1];
      `DIT_CLK_EXT4: pri_tick = tick_ext[2];
      `DIT_CLK_EXT8: pri_tick = tick_ext[3];
      // Reserved codes hold the counter still
      default:       pri_tick = 1'b0;
    endcase
  end

  // Carrier clock stands in as rising edges of the primary output toggle
  assign carrier_edge = tmo_ff_r & ~carrier_prev_r;

  // Secondary count clock select
  always @*
  begin
    case (secondary_clksel)
      `DIT_CLK_S64:    sec_tick = tick_sys64;
      `DIT_CLK_S256:   sec_tick = tick_sys256;
      `DIT_CLK_PMATCH: sec_tick = primary_match_irq;
      `DIT_CLK_PCARR:  sec_tick = carrier_edge;
      default:         sec_tick = 1'b0;
    endcase
  end

  // Two separate channels; only the primary feeds a pin
  dit_timer #(
    .CNT_W (CNT_W)
  ) u_primary (
    .clk     (CLOCK),
    .rst_n   (RESETN),
    .enable  (primary_count_enable),
    .tick    (pri_tick),
    .compare (primary_compare_r),
    .count_r (primary_counter),
    .match_r (primary_match_irq)
  );

  dit_timer #(
    .CNT_W (CNT_W)
  ) u_secondary (
    .clk     (CLOCK),
    .rst_n   (RESETN),
    .enable  (secondary_count_enable),
    .tick    (sec_tick),
    .compare (secondary_compare_r),
    .count_r (secondary_counter),
    .match_r (secondary_match_irq)
  );

  assign PRI_IRQ = primary_match_irq;
  assign SEC_IRQ = secondary_match_irq;

  // Primary output toggle; starts low whenever counting stops
  always @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      tmo_ff_r       <= 1'b0;
      carrier_prev_r <= 1'b0;
    end
    else
    begin
      carrier_prev_r <= tmo_ff_r;
      if (!primary_count_enable)
        tmo_ff_r <= 1'b0;
      else if (primary_match_irq)
        tmo_ff_r <= ~tmo_ff_r;
    end
  end

  // Pin level: timer output when enabled, else the port latch
  always @(posedge CLOCK)
  begin
    if (!RESETN)
      TMO_OUT <= 1'b0;
    else
      TMO_OUT <= pin_level[`DIT_DIR_OUT_PIN];
  end

  // One slice per port-2 pin; the direction bit alone gates each buffer
  genvar m;
  generate
    for (m = 0; m < PIN_N; m = m + 1)
    begin : g_pin
      assign pin_oe[m] = ~port2_direction_r[m];
      if (m == `DIT_DIR_OUT_PIN)
      begin : g_timer_pin
        // Counting goes on unseen while the pin shows the latch
        assign pin_level[m] = pin_output_enable ? tmo_ff_r : pin_latch_r[m];
      end
      else
      begin : g_port_pin
        assign pin_level[m] = pin_latch_r[m];
      end
    end
  endgenerate

  assign TMO_OE   = pin_oe[`DIT_DIR_OUT_PIN];
  assign PIN1_OE  = pin_oe[`DIT_DIR_CLK_PIN];
  // Clock-in pin only ever shows its latch; the timer never drives it
  assign PIN1_OUT = pin_level[`DIT_DIR_CLK_PIN];

endmodule

`default_nettype wire

// ---- tb/dit_top_properties.sv ----
/*
  Concurrent checks on the ports of the dual interval timer top.
  Assumes one clock domain and an APB master that idles between transfers.
*/
`default_nettype none
`include "dit_regs.vh"

module dit_top_properties #(
  parameter CNT_W = 8
) (
  input wire logic                   CLOCK,
  input wire logic                   RESETN,
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PWRITE,
  input wire logic [`DIT_ADDR_W-1:0] PADDR,
  input wire logic [31:0]            PWDATA,
  input wire logic [31:0]            PRDATA,
  input wire logic                   PREADY,
  input wire logic                   PSLVERR,
  input wire logic                   EXT_CLK_IN,
  input wire logic                   TMO_OUT,
  input wire logic                   TMO_OE,
  input wire logic                   PIN1_OUT,
  input wire logic                   PIN1_OE,
  input wire logic                   PRI_IRQ,
  input wire logic                   SEC_IRQ
);
  localparam logic [17:0] A_DIR  = {`DIT_IDX_PORT2_DIR, 2'b00};
  localparam logic [17:0] A_PCTL = {`DIT_IDX_PRI_CTRL, 2'b00};
  localparam logic [17:0] A_PCMP = {`DIT_IDX_PRI_CMP, 2'b00};
  localparam logic [17:0] A_PCNT = {`DIT_IDX_PRI_CNT, 2'b00};

  logic        wr;
  logic        rd;
  logic [7:0]  pctl_r;
  logic [7:0]  pcmp_r;
  logic        valid_r;
  logic [11:0] gap_r;

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;

  // Shadow of primary setup; the first gap after any change is not judged
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      pctl_r  <= 8'h00;
      pcmp_r  <= 8'h00;
      valid_r <= 1'b0;
      gap_r   <= 12'h000;
    end
    else
    begin
      if (wr && PADDR == A_PCTL)
        pctl_r <= PWDATA[7:0];
      if (wr && PADDR == A_PCMP)
        pcmp_r <= PWDATA[7:0];
      if (wr && (PADDR == A_PCTL || PADDR == A_PCMP))
        valid_r <= 1'b0;
      else if (PRI_IRQ)
        valid_r <= 1'b1;
      gap_r <= PRI_IRQ ? 12'h000 : gap_r + 12'h001;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  chk_ready_zero_wait:
    assert property (PSEL && PENABLE |-> PREADY)
    else $error("PREADY low in access phase");
  chk_unmapped_error:
    assert property (rd && PADDR[17:2] == 16'h0000 |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped read not refused");
  chk_reset_pins:
    assert property ($rose(RESETN) |-> !TMO_OE && !PIN1_OE && !PRI_IRQ && !SEC_IRQ)
    else $error("pins or irqs active after reset");
  chk_dir_read_ones:
    assert property (rd && PADDR == A_DIR |-> PRDATA[7:2] == 6'h3f)
    else $error("direction upper bits not one");
  chk_out_pin_oe:
    assert property (wr && PADDR == A_DIR |=> TMO_OE == !$past(PWDATA[0]))
    else $error("output pin enable wrong");
  chk_clk_pin_oe:
    assert property (wr && PADDR == A_DIR |=> PIN1_OE == !$past(PWDATA[1]))
    else $error("clock pin enable wrong");
  chk_stop_no_irq:
    assert property (wr && PADDR == A_PCTL && !PWDATA[7] |=> ##1 !PRI_IRQ [*2])
    else $error("irq after counter stop");
  chk_stop_count_zero:
    assert property (rd && PADDR == A_PCNT && !pctl_r[7] && !$past(pctl_r[7])
                     && !$past(pctl_r[7], 2) |-> PRDATA == 32'h0)
    else $error("stopped counter not zero");
  chk_stopped_out_low:
    assert property ($past(pctl_r[0]) && !$past(pctl_r[7], 2) |-> !TMO_OUT)
    else $error("timer output not low while stopped");
  chk_pri_gap:
    assert property (PRI_IRQ && valid_r && pctl_r[7] && pctl_r[5:4] == 2'b00
                     |-> gap_r == (pctl_r[3] ? {2'b00, pcmp_r, 2'b11} : {4'h0, pcmp_r}))
    else $error("primary match interval wrong");
endmodule

bind dit_top dit_top_properties #(.CNT_W(CNT_W)) u_dit_top_properties (
  .CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EXT_CLK_IN(EXT_CLK_IN), .TMO_OUT(TMO_OUT), .TMO_OE(TMO_OE), .PIN1_OUT(PIN1_OUT),
  .PIN1_OE(PIN1_OE), .PRI_IRQ(PRI_IRQ), .SEC_IRQ(SEC_IRQ));
`default_nettype wire

// ---- tb/dit_top_tb_top.sv ----
/*
  Self-checking bench for the dual interval timer top.
  Assumes zero-wait APB and an external pin toggled every clock.
*/
`default_nettype none
`include "dit_regs.vh"

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module dit_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [17:0] paddr   = 18'h00000;
  logic [31:0] pwdata  = 32'h0;
  logic        ext_clk = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tmo_out;
  logic        tmo_oe;
  logic        pin1_oe;
  logic        pin1_out;
  logic        pri_irq;
  logic        sec_irq;
  logic [31:0] rdv;
  logic        errv;
  int          fail_count = 0;
  int          checks     = 0;
  int          div[6]     = '{1, 4, 2, 4, 8, 16};
  int          cmp[6]     = '{255, 0, 3, 3, 3, 3};
  int          scmp[4]    = '{1, 0, 1, 1};
  int          sexp[4]    = '{128, 256, 6, 12};

  always #10 clk = ~clk;
  // Free-running pin gives one rising edge every two clocks
  always @(posedge clk) ext_clk <= ~ext_clk;

  dit_top u_dit_top (
    .CLOCK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_CLK_IN(ext_clk), .TMO_OUT(tmo_out), .TMO_OE(tmo_oe), .PIN1_OUT(pin1_out),
    .PIN1_OE(pin1_oe), .PRI_IRQ(pri_irq), .SEC_IRQ(sec_irq));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic timed_out();
    fail_count++;
    print_verdict();
  endtask

  // One idle edge after each transfer keeps drivers single per time step
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        timed_out();
    end
    rdv     = prdata;
    errv    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic measure(input logic sec, input int exp, input string nm);
    int n;
    n = 0;
    while ((sec ? sec_irq : pri_irq) !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 9000)
        timed_out();
    end
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 9000)
        timed_out();
    end
    while ((sec ? sec_irq : pri_irq) !== 1'b1);
    `CHK(nm, exp, n)
  endtask

  task automatic t_regs();
    apb(0, `DIT_IDX_PORT2_DIR, 8'h00);
    `CHK("dir reset", 32'h000000ff, rdv)
    `CHK("oe reset", 2'b00, {pin1_oe, tmo_oe})
    apb(1, `DIT_IDX_PORT2_DIR, 8'h02);
    `CHK("oe out only", 2'b01, {pin1_oe, tmo_oe})
    apb(1, `DIT_IDX_PORT2_DIR, 8'h00);
    apb(0, `DIT_IDX_PORT2_DIR, 8'h00);
    `CHK("dir fixed ones", 32'h000000fc, rdv)
    `CHK("oe both", 2'b11, {pin1_oe, tmo_oe})
    apb(0, 16'h0000, 8'h00);
    `CHK("unmapped err", 1'b1, errv)
    $display("test regs done");
  endtask

  task automatic t_pri();
    apb(1, `DIT_IDX_PORT2_DIR, 8'h02);
    for (int c = 0; c < 6; c++)
    begin
      apb(1, `DIT_IDX_PRI_CTRL, 8'h00);
      apb(1, `DIT_IDX_PRI_CMP, cmp[c][7:0]);
      apb(1, `DIT_IDX_PRI_CTRL, 8'h80 | 8'(c << 3));
      measure(1'b0, (cmp[c] + 1) * div[c], "pri interval");
    end
    $display("test primary clocks done");
  endtask

  task automatic t_sec();
    apb(1, `DIT_IDX_PRI_CTRL, 8'h00);
    apb(1, `DIT_IDX_PRI_CMP, 8'h02);
    apb(1, `DIT_IDX_PRI_CTRL, 8'h80);
    for (int c = 0; c < 4; c++)
    begin
      apb(1, `DIT_IDX_SEC_CTRL, 8'h00);
      apb(1, `DIT_IDX_SEC_CMP, scmp[c][7:0]);
      apb(1, `DIT_IDX_SEC_CTRL, 8'h80 | 8'(c << 3));
      measure(1'b1, sexp[c], "sec interval");
    end
    measure(1'b0, 3, "pri beside sec");
    apb(1, `DIT_IDX_SEC_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    apb(0, `DIT_IDX_SEC_CNT, 8'h00);
    `CHK("sec stopped", 32'h0, rdv)
    $display("test secondary clocks done");
  endtask

  task automatic t_lower();
    int n;
    n = 0;
    apb(1, `DIT_IDX_PRI_CTRL, 8'h00);
    apb(0, `DIT_IDX_PRI_CNT, 8'h00);
    `CHK("pri stopped", 32'h0, rdv)
    apb(1, `DIT_IDX_PRI_CMP, 8'hff);
    apb(1, `DIT_IDX_PRI_CTRL, 8'h80);
    repeat (60) @(posedge clk);
    apb(0, `DIT_IDX_PRI_CNT, 8'h00);
    `CHK("counting", 1'b1, rdv > 32'd5)
    apb(1, `DIT_IDX_PRI_CMP, 8'h05);
    while (pri_irq !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 600)
        timed_out();
    end
    // Early match here means the counter did not wrap through 255
    `CHK("wrap before match", 1'b1, n > 150)
    measure(1'b0, 6, "new compare");
    $display("test compare lowered done");
  endtask

  task automatic t_pin();
    int n;
    n = 0;
    // Primary still toggles here with output disabled
    apb(1, `DIT_IDX_PIN_LATCH, 8'h03);
    repeat (12)
    begin
      @(posedge clk);
      if (tmo_out !== 1'b1)
        n++;
    end
    `CHK("pin holds latch", 0, n)
    `CHK("clk pin latch", 1'b1, pin1_out)
    apb(0, `DIT_IDX_PIN_STATE, 8'h00);
    `CHK("pin state out", 1'b1, rdv[0])
    `CHK("pin state upper", 30'h0, rdv[31:2])
    apb(1, `DIT_IDX_PRI_CTRL, 8'h00);
    apb(1, `DIT_IDX_PIN_LATCH, 8'h00);
    apb(1, `DIT_IDX_PORT2_DIR, 8'h02);
    apb(1, `DIT_IDX_PRI_CTRL, 8'h01);
    @(posedge clk);
    `CHK("out low stopped", 1'b0, tmo_out)
    `CHK("clk pin latch clear", 1'b0, pin1_out)
    apb(1, `DIT_IDX_PRI_CMP, 8'h02);
    apb(1, `DIT_IDX_PRI_CTRL, 8'h81);
    n = 0;
    while (tmo_out !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        timed_out();
    end
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        timed_out();
    end
    while (tmo_out === 1'b1);
    `CHK("square half period", 3, n)
    $display("test timer pin done");
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_pri();
    t_sec();
    t_lower();
    t_pin();
    print_verdict();
  end
endmodule
`default_nettype wire
